// [design/aux_led_sink_blink_control.sv]
`timescale 1ns/1ps
// Notes on behaviour
// R1: One control bit picks linear (0) or square (1) fade law for all sinks.
// R2: Low three control bits enable sinks 0 to 2; zero keeps a sink off.
// R3: Shared two-bit on-time: 0.2, 0.6, 0.8 or 1.2 seconds lit.
// R4: Sink 2 off-time in bits 5:4; zero means always lit, else 0.6/0.8/1.2 s.
// R5: Sink 1 off-time field, same coding; zero keeps the sink lit.
// R6: Sink 0 off-time in bits 1:0; zero keeps lit, else 0.6/0.8/1.2 s.
// R7: Enabled sink with nonzero off-time alternates lit and dark phases.
// R8: Host sets fade times before enabling; code zero disables fading.
// R9: Each sink takes its target current from its own six-bit code.
// R10: Phase timers run on a fixed timebase; lit phase restarts on enable.
module aux_led_sink_blink_control
  import aux_sink_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic CLK_SYS, // 10 MHz system clock
  input wire logic RST_N, // Async reset, active low
  input wire reg_req_t REG_REQ, // Register port request
  output logic [DATA_W-1:0] REG_RDATA, // Read data
  output logic REG_RVALID, // Read data valid pulse
  output logic [SINKS-1:0] SINK_LIT, // Sinks in lit phase
  output logic [SINKS-1:0][CODE_W-1:0] SINK_CURRENT // Present sink codes
);

  logic [DATA_W-1:0] control_reg;
  logic [DATA_W-1:0] timers_reg;
  logic [DATA_W-1:0] fade_reg;
  logic [DATA_W-1:0] cur_reg [SINKS];
  logic [DATA_W-1:0] rdata_reg;
  logic rvalid_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [$clog2(TICK_CYCLES)-1:0] div_reg;
  logic tick_reg;
  logic [SINKS-1:0] lit_w;
  logic [FRAC_W-1:0] frac_w [SINKS];
  logic [SINKS-1:0][CODE_W-1:0] current_reg;
  logic law_square;

  // Index of a current register, or SINKS when the address is elsewhere
  function automatic int cur_index(input logic [ADDR_W-1:0] a);
    int idx;
    idx = SINKS;
    for (int k = 0; k < SINKS; k++) begin
      if (a == ADDR_CUR0 + ADDR_W'(k)) begin
        idx = k;
      end
    end
    return idx;
  endfunction

  // Code scaled by fade fraction under the selected law
  function automatic logic [CODE_W-1:0] scale(input logic [CODE_W-1:0] code,
                                              input logic [FRAC_W-1:0] f,
                                              input logic sq);
    logic [19:0] prod;
    prod = 20'h00000;
    if (sq) begin
      prod = 20'(code) * 20'(f) * 20'(f);
      return prod[17:12];
    end else begin
      prod = 20'(code) * 20'(f);
      return prod[11:6];
    end
  endfunction

  // Control register write
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      control_reg <= RST_CONTROL;
    end else if (REG_REQ.wr && REG_REQ.addr == ADDR_CONTROL) begin
      control_reg <= REG_REQ.wdata & CONTROL_MASK; // R1 R2
    end
  end

  // On and off timer register write
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      timers_reg <= RST_TIMERS;
    end else if (REG_REQ.wr && REG_REQ.addr == ADDR_TIMERS) begin
      timers_reg <= REG_REQ.wdata; // R3 R4 R5 R6
    end
  end

  // Fade timer register write
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      fade_reg <= RST_FADE;
    end else if (REG_REQ.wr && REG_REQ.addr == ADDR_FADE) begin
      fade_reg <= REG_REQ.wdata;
    end
  end

  // Per-sink current code writes
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      for (int k = 0; k < SINKS; k++) begin
        cur_reg[k] <= RST_CUR;
      end
    end else if (REG_REQ.wr && cur_index(REG_REQ.addr) < SINKS) begin
      cur_reg[cur_index(REG_REQ.addr)] <= REG_REQ.wdata & CUR_MASK; // R9
    end
  end

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rdata_next = RDATA_UNMAPPED;
    case (REG_REQ.addr)
      ADDR_CONTROL: rdata_next = control_reg;
      ADDR_TIMERS: rdata_next = timers_reg;
      ADDR_FADE: rdata_next = fade_reg;
      default: begin
        if (cur_index(REG_REQ.addr) < SINKS) begin
          rdata_next = cur_reg[cur_index(REG_REQ.addr)];
        end
      end
    endcase
  end

  // Registered read answer, one cycle after the strobe
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rdata_reg <= '0;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= REG_REQ.rd;
      if (REG_REQ.rd) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // Millisecond timebase; free running so all sinks share one grid
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      div_reg <= '0;
      tick_reg <= 1'b0;
    end else if (div_reg == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)) begin
      div_reg <= '0;
      tick_reg <= 1'b1; // R10
    end else begin
      div_reg <= div_reg + 1'b1;
      tick_reg <= 1'b0;
    end
  end

  assign law_square = control_reg[LAW_BIT]; // R1

  // One channel per sink, durations decoded from the shared fields
  for (genvar g = 0; g < SINKS; g++) begin : g_sink
    blink_cfg_t cfg;
    assign cfg.on_ms = ON_MS[timers_reg[ONT_LSB +: 2]]; // R3
    assign cfg.off_ms = OFF_MS[timers_reg[OFFT_LSB + OFFT_STRIDE*g +: 2]]; // R4 R5 R6
    assign cfg.fi_ms = FADE_MS[fade_reg[FI_LSB +: 4]];
    assign cfg.fo_ms = FADE_MS[fade_reg[FO_LSB +: 4]];
    aux_sink_channel u_chan (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .tick(tick_reg),
      .enable(control_reg[EN_LSB + g]), // R2
      .cfg(cfg),
      .lit(lit_w[g]),
      .frac(frac_w[g])
    );
  end

  // Output current codes, registered; zero whenever the fade is at rest off
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      current_reg <= '0;
    end else begin
      for (int k = 0; k < SINKS; k++) begin
        current_reg[k] <= scale(cur_reg[k][CUR_LSB +: CODE_W], frac_w[k], law_square); // R9 R1
      end
    end
  end

  assign REG_RDATA = rdata_reg;
  assign REG_RVALID = rvalid_reg;
  assign SINK_LIT = lit_w;
  assign SINK_CURRENT = current_reg;

endmodule

// [design/aux_sink_channel.sv]
`timescale 1ns/1ps
module aux_sink_channel
  import aux_sink_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic tick, // One-cycle millisecond pulse
  input wire logic enable, // Sink enable bit
  input wire blink_cfg_t cfg, // Decoded durations
  output logic lit, // Sink in lit phase
  output logic [FRAC_W-1:0] frac // Fade fraction, 0 to full
);

  typedef enum logic [1:0] {S_IDLE, S_LIT, S_DARK} phase_t;

  phase_t state_reg;
  logic [MS_W-1:0] cnt_reg;
  logic [MS_W-1:0] acc_reg;
  logic [FRAC_W-1:0] frac_reg;
  logic up_reg;
  logic [MS_W-1:0] cnt_next;
  logic target_up;
  logic [MS_W-1:0] fade_ms;
  logic [MS_W-1:0] acc_sum;

  assign cnt_next = cnt_reg + 13'h0001;

  // Blink phase sequencing; the lit phase restarts on every enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      cnt_reg <= '0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (enable) begin // R10
            state_reg <= S_LIT;
            cnt_reg <= '0;
          end
        end
        S_LIT: begin
          if (!enable) begin
            state_reg <= S_IDLE;
          end else if (cfg.off_ms == '0) begin
            cnt_reg <= '0; // Blink timer off: stays lit
          end else if (tick) begin
            if (cnt_next >= cfg.on_ms) begin // R7
              state_reg <= S_DARK;
              cnt_reg <= '0;
            end else begin
              cnt_reg <= cnt_next;
            end
          end
        end
        S_DARK: begin
          if (!enable) begin
            state_reg <= S_IDLE;
          end else if (cfg.off_ms == '0) begin
            state_reg <= S_LIT; // Timer disabled mid-dark
            cnt_reg <= '0;
          end else if (tick) begin
            if (cnt_next >= cfg.off_ms) begin // R7
              state_reg <= S_LIT;
              cnt_reg <= '0;
            end else begin
              cnt_reg <= cnt_next;
            end
          end
        end
        default: begin
          state_reg <= S_IDLE;
          cnt_reg <= '0;
        end
      endcase
    end
  end

  assign target_up = (state_reg == S_LIT);
  assign fade_ms = target_up ? cfg.fi_ms : cfg.fo_ms;
  assign acc_sum = acc_reg + {6'h00, FRAC_FULL};

  // Fade ramp: accumulator spreads full scale evenly over the fade time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frac_reg <= '0;
      acc_reg <= '0;
      up_reg <= 1'b0;
    end else begin
      up_reg <= target_up;
      if (up_reg != target_up) begin
        acc_reg <= '0; // Fresh ramp on direction change
      end else if (fade_ms == '0) begin
        frac_reg <= target_up ? FRAC_FULL : '0; // Fading disabled: step at once
        acc_reg <= '0;
      end else if (tick && (target_up ? (frac_reg != FRAC_FULL) : (frac_reg != '0))) begin
        if (acc_sum >= fade_ms) begin
          acc_reg <= acc_sum - fade_ms;
          frac_reg <= target_up ? frac_reg + 7'h01 : frac_reg - 7'h01;
        end else begin
          acc_reg <= acc_sum;
        end
      end
    end
  end

  assign lit = target_up;
  assign frac = frac_reg;

endmodule

// [design/aux_sink_pkg.sv]
package aux_sink_pkg;

  // Clock and timebase
  localparam int CLK_PERIOD_NS = 100;
  localparam int TIMEBASE_NS = 1000000;
  localparam int TICK_CYCLES_DEF = (TIMEBASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int SINKS = 3;
  localparam int CODE_W = 6;
  localparam int MS_W = 13;
  localparam int FRAC_W = 7;

  // Register offsets
  localparam logic [7:0] ADDR_CONTROL = 8'h11;
  localparam logic [7:0] ADDR_TIMERS = 8'h12;
  localparam logic [7:0] ADDR_FADE = 8'h13;
  localparam logic [7:0] ADDR_CUR0 = 8'h14;

  // Field positions
  localparam int LAW_BIT = 3;
  localparam int EN_LSB = 0;
  localparam int ONT_LSB = 6;
  localparam int OFFT_LSB = 0;
  localparam int OFFT_STRIDE = 2;
  localparam int FO_LSB = 4;
  localparam int FI_LSB = 0;
  localparam int CUR_LSB = 0;

  // Writable masks, reserved bits read as zero
  localparam logic [7:0] CONTROL_MASK = 8'h0f;
  localparam logic [7:0] CUR_MASK = 8'h3f;

  // Reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_TIMERS = 8'h00;
  localparam logic [7:0] RST_FADE = 8'h00;
  localparam logic [7:0] RST_CUR = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // Fade fraction full scale
  localparam logic [FRAC_W-1:0] FRAC_FULL = 7'h40;

  // Durations in milliseconds, indexed by field code
  localparam logic [MS_W-1:0] ON_MS [4] = '{13'd200, 13'd600, 13'd800, 13'd1200};
  localparam logic [MS_W-1:0] OFF_MS [4] = '{13'd0, 13'd600, 13'd800, 13'd1200};
  localparam logic [MS_W-1:0] FADE_MS [16] = '{
    13'd0, 13'd300, 13'd600, 13'd900, 13'd1200, 13'd1500, 13'd1800, 13'd2100,
    13'd2400, 13'd2700, 13'd3000, 13'd3500, 13'd4000, 13'd4500, 13'd5000, 13'd5500};

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Per-sink timing, in milliseconds
  typedef struct packed {
    logic [MS_W-1:0] on_ms;
    logic [MS_W-1:0] off_ms;
    logic [MS_W-1:0] fi_ms;
    logic [MS_W-1:0] fo_ms;
  } blink_cfg_t;

endpackage

// [verification/aux_sink_assertions.sv]
`timescale 1ns/1ps
module aux_sink_chk
  import aux_sink_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic CLK_SYS, // Clock
  input wire logic RST_N, // Reset, active low
  input wire reg_req_t REG_REQ, // Request
  input wire logic [DATA_W-1:0] REG_RDATA, // Read data
  input wire logic REG_RVALID, // Read valid
  input wire logic [SINKS-1:0] SINK_LIT, // Lit phases
  input wire logic [SINKS-1:0][CODE_W-1:0] SINK_CURRENT // Codes
);
  logic [3:0] ctl_reg;
  logic [7:0] tim_reg;
  logic [15:0] run_reg;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // Shadows of control and timers
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ctl_reg <= 4'h0;
      tim_reg <= 8'h00;
    end else if (REG_REQ.wr && REG_REQ.addr == ADDR_CONTROL) begin
      ctl_reg <= REG_REQ.wdata[3:0];
    end else if (REG_REQ.wr && REG_REQ.addr == ADDR_TIMERS) begin
      tim_reg <= REG_REQ.wdata;
    end
  end
  // Lit run of sink 0; timers must stay put mid-phase for this to hold
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      run_reg <= 16'h0000;
    end else begin
      run_reg <= SINK_LIT[0] ? run_reg + 16'h0001 : 16'h0000;
    end
  end
  sequence rd_ctl_s;
    REG_REQ.rd && REG_REQ.addr == ADDR_CONTROL;
  endsequence
  sequence lit_end_s;
    $fell(SINK_LIT[0]) && ctl_reg[0];
  endsequence
  rd_answer_a: assert property (REG_REQ.rd |=> REG_RVALID)
    else $error("read not answered");
  rvalid_pulse_a: assert property (!REG_REQ.rd |=> !REG_RVALID)
    else $error("spurious read valid");
  ctl_read_a: assert property (rd_ctl_s |=> REG_RDATA == {4'h0, $past(ctl_reg)})
    else $error("control read wrong");
  tim_read_a: assert property (REG_REQ.rd && REG_REQ.addr == ADDR_TIMERS
    |=> REG_RDATA == $past(tim_reg)) else $error("timers read wrong");
  off_dark_a: assert property ((SINK_LIT & ~ctl_reg[2:0] & ~$past(ctl_reg[2:0])) == 3'h0)
    else $error("disabled sink lit");
  rise_lit_a: assert property ($rose(ctl_reg[0]) |=> SINK_LIT[0])
    else $error("enable did not light");
  steady1_a: assert property ((ctl_reg[1] && tim_reg[3:2] == 2'b00) [*3] |-> SINK_LIT[1])
    else $error("sink 1 not steady");
  steady2_a: assert property ((ctl_reg[2] && tim_reg[5:4] == 2'b00) [*3] |-> SINK_LIT[2])
    else $error("sink 2 not steady");
  lit_len_a: assert property (lit_end_s |-> run_reg + TICK_CYCLES >=
    ON_MS[tim_reg[7:6]] * TICK_CYCLES && run_reg <= ON_MS[tim_reg[7:6]] * TICK_CYCLES
    + TICK_CYCLES) else $error("lit phase length wrong");
endmodule
bind aux_led_sink_blink_control aux_sink_chk #(.TICK_CYCLES(TICK_CYCLES)) chk (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
  .REG_RVALID(REG_RVALID), .SINK_LIT(SINK_LIT), .SINK_CURRENT(SINK_CURRENT));

// [verification/led_indicator.sv]
`timescale 1ns/1ps
module led_indicator (
  input wire logic clk, // System clock
  input wire logic rst_n, // Reset, active low
  input wire logic lit, // Sink lit phase
  output logic [15:0] dark_len // Last dark run, cycles
);
  logic [15:0] run_reg;
  // Dark run latched as the LED relights
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_reg <= 16'h0000;
      dark_len <= 16'h0000;
    end else if (!lit) begin
      run_reg <= run_reg + 16'h0001;
    end else begin
      run_reg <= 16'h0000;
      if (run_reg != 16'h0000) begin
        dark_len <= run_reg;
      end
    end
  end
endmodule

// [verification/testbench.sv]
`timescale 1ns/1ps
module testbench
  import aux_sink_pkg::*;
;
  localparam int T = 4;
  typedef struct {logic [7:0] a, w, r;} row_t;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  reg_req_t req = '0;
  logic [7:0] rdata, d;
  logic rvalid;
  logic [2:0] lit;
  logic [2:0][5:0] cur;
  logic [15:0] dark;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  // Address, write value, expected read
  row_t rows [6] = '{'{8'h11, 8'hf8, 8'h08}, '{8'h12, 8'ha5, 8'ha5}, '{8'h13, 8'h3c, 8'h3c},
    '{8'h14, 8'hff, 8'h3f}, '{8'h15, 8'h2a, 8'h2a}, '{8'h40, 8'h55, 8'h00}};
  aux_led_sink_blink_control #(.TICK_CYCLES(T)) dut (.CLK_SYS(clk_sys), .RST_N(rst_n),
    .REG_REQ(req), .REG_RDATA(rdata), .REG_RVALID(rvalid), .SINK_LIT(lit), .SINK_CURRENT(cur));
  led_indicator led0 (.clk(clk_sys), .rst_n(rst_n), .lit(lit[0]), .dark_len(dark));
  // Clock, 100 ns
  initial forever #50 clk_sys = ~clk_sys;
  task automatic close_out();
    $display("Checked %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge clk_sys) req <= '{a, w, 1'b1, 1'b0};
    @(posedge clk_sys) req <= '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys) req <= '0;
    #1 d = rdata;
    chk(rvalid, 1'b1);
  endtask
  // Polled at falling edges so the lit level has settled
  task automatic wait_lit(input logic v);
    int n = 0;
    while (lit[0] !== v && n < 20000) begin
      @(negedge clk_sys);
      n++;
    end
    chk(lit[0], v);
  endtask
  // Hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      chk(d, rows[i].r);
    end
    $display("Test rows done");
    // Reset mid-run clears what the rows left
    @(posedge clk_sys) rst_n <= 1'b0;
    @(posedge clk_sys) rst_n <= 1'b1;
    for (int a = 8'h11; a <= 8'h16; a++) begin
      rd(a[7:0]);
      chk(d, 8'h00);
    end
    $display("Test reset done");
    // Fading off first, so steady sinks jump to full code
    wr(ADDR_FADE, 8'h00);
    wr(8'h15, 8'h2a);
    wr(8'h16, 8'h15);
    wr(ADDR_CONTROL, 8'h0e);
    repeat (4) @(posedge clk_sys);
    #1 chk(lit, 3'b110);
    chk(cur[1], 6'h2a);
    chk(cur[2], 6'h15);
    $display("Test steady done");
    wr(ADDR_CUR0, 8'h3f);
    wr(ADDR_CONTROL, 8'h0f);
    // Timers written early in each lit phase
    for (int c = 1; c < 4; c++) begin
      wr(ADDR_TIMERS, {c[1:0], 4'h0, c[1:0]});
      wait_lit(1'b0);
      wait_lit(1'b1);
      @(negedge clk_sys);
      chk(dark + T >= OFF_MS[c] * T && dark <= OFF_MS[c] * T + T, 1'b1);
    end
    $display("Test blink done");
    wait_lit(1'b0);
    wr(ADDR_TIMERS, 8'h00);
    repeat (2) @(negedge clk_sys);
    chk(lit[0], 1'b1);
    repeat (3) @(negedge clk_sys);
    chk(cur[0], 6'h3f);
    wr(ADDR_CONTROL, 8'h00);
    // Enable drop reaches the channel one cycle after the write lands
    repeat (2) @(negedge clk_sys);
    chk(lit, 3'b000);
    $display("Test relight and disable done");
    // Square-law fade, 300 ms each way; a linear law would sit near half code
    wr(8'h15, 8'h3f);
    wr(ADDR_FADE, 8'h11);
    wr(ADDR_CONTROL, 8'h0a);
    repeat (600) @(posedge clk_sys);
    #1 chk(cur[1] >= 6'h0c && cur[1] <= 6'h12, 1'b1);
    repeat (700) @(posedge clk_sys);
    #1 chk(cur[1], 6'h3f);
    wr(ADDR_CONTROL, 8'h08);
    repeat (600) @(posedge clk_sys);
    #1 chk(cur[1] >= 6'h0c && cur[1] <= 6'h12, 1'b1);
    chk(lit[1], 1'b0);
    repeat (700) @(posedge clk_sys);
    #1 chk(cur[1], 6'h00);
    $display("Test square fade done");
    close_out();
  end
endmodule
